//--- hw/bbm_pkg.sv
// bbm_pkg: constants and carrier types for the bad block manager
// assumes a flash operation engine outside that runs the pin protocol
package bbm_pkg;
  // ----------------------------------------------------------------
  // geometry and marks
  // ----------------------------------------------------------------
  localparam int unsigned BLOCK_COUNT     = 2048;
  localparam int unsigned MIN_GOOD_BLOCKS = 2008;
  localparam int unsigned BLK_W           = 11;
  localparam logic [7:0]  BAD_MARK        = 8'h00;
  localparam logic [7:0]  STATUS_READ_CMD = 8'h70;
  localparam int unsigned STAT_FAIL_BIT   = 0;
  localparam logic [7:0]  PAD_BYTE        = 8'hff;
  // ----------------------------------------------------------------
  // error correction and wear
  // ----------------------------------------------------------------
  localparam int unsigned ECC_MIN_BITS    = 8;
  localparam int unsigned ECC_UNIT_BYTES  = 512;
  localparam int unsigned ERR_W           = 4;
  localparam int unsigned WEAR_W          = 16;

  typedef enum logic [1:0] {
    BBM_OP_READ,
    BBM_OP_PROGRAM,
    BBM_OP_ERASE,
    BBM_OP_MARK
  } bbm_op_type;

  // request toward the flash operation engine
  typedef struct packed {
    bbm_op_type       op;
    logic [BLK_W-1:0] block;
  } bbm_req_type;

  // result of one flash operation
  typedef struct packed {
    logic [7:0]       status;
    logic [7:0]       mark;
    logic [ERR_W-1:0] ecc_errs;
    logic             ecc_fail;
  } bbm_rsp_type;
endpackage

//--- hw/bbm_table.sv
// bbm_table: one retired flag per block, flip-flop storage
// assumes one write per cycle at most; read is combinational
`timescale 1ns/100ps
module bbm_table #(
  parameter int unsigned BLOCKS = bbm_pkg::BLOCK_COUNT,
  parameter int unsigned AW     = bbm_pkg::BLK_W
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          set_in,
  input  wire logic [AW-1:0] set_idx_in,
  input  wire logic [AW-1:0] rd_idx_in,
  output logic               rd_bad_out
);
  logic [BLOCKS-1:0] bad_q;
  logic [BLOCKS-1:0] bad_d;

  // flags only ever set; a retired block comes back only when reset clears the table
  always_comb begin
    bad_d = bad_q;
    if (set_in) begin
      bad_d[set_idx_in] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bad_q <= '0;
    end else begin
      bad_q <= bad_d;
    end
  end

  assign rd_bad_out = bad_q[rd_idx_in];
endmodule // bbm_table

//--- hw/bbm_ctrl.sv
// bbm_ctrl: host-side bad block manager for a parallel flash
// assumes an operation engine that issues commands on the flash pins and
// returns the status byte (read after the status read command) or data
`timescale 1ns/100ps
module bbm_ctrl #(
  parameter int unsigned BLOCKS   = bbm_pkg::BLOCK_COUNT,
  parameter int unsigned ECC_BITS = bbm_pkg::ECC_MIN_BITS,
  parameter int unsigned AW       = bbm_pkg::BLK_W
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  // user side
  input  wire logic                 usr_valid_in,
  input  wire bbm_pkg::bbm_op_type  usr_op_in,
  input  wire logic [AW-1:0]        usr_block_in,
  output logic                      usr_ready_out,
  output logic                      usr_done_out,
  output logic                      usr_ok_out,
  output logic [AW-1:0]             usr_block_out,
  output logic                      rewrite_out,
  output logic                      scan_busy_out,
  output logic [7:0]                pad_byte_out,
  // engine side
  output logic                      eng_valid_out,
  output bbm_pkg::bbm_req_type      eng_req_out,
  input  wire logic                 eng_done_in,
  input  wire bbm_pkg::bbm_rsp_type eng_rsp_in
);
  localparam int unsigned EW = bbm_pkg::ERR_W;

  typedef enum logic [2:0] {
    ST_SCAN, ST_SCAN_WAIT, ST_IDLE, ST_ISSUE, ST_WAIT
  } bbm_state_type;

  bbm_state_type    state_q, state_d;
  logic [AW-1:0]    scan_q, scan_d;
  logic [AW-1:0]    tgt_q, tgt_d;
  logic [AW-1:0]    nxt_q, nxt_d;
  bbm_pkg::bbm_op_type op_q, op_d;
  logic             done_q, done_d;
  logic             ok_q, ok_d;
  logic [AW-1:0]    blk_out_q, blk_out_d;
  logic             rew_q, rew_d;
  logic             set_bad;
  logic [AW-1:0]    set_idx;
  logic [AW-1:0]    rd_idx;
  logic             rd_bad;

  function automatic logic [AW-1:0] next_blk(input logic [AW-1:0] b);
    next_blk = (b == AW'(BLOCKS - 1)) ? '0 : AW'(b + 1'b1);
  endfunction

  bbm_table #(.BLOCKS(BLOCKS), .AW(AW)) u_table (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .set_in     (set_bad),
    .set_idx_in (set_idx),
    .rd_idx_in  (rd_idx),
    .rd_bad_out (rd_bad)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    scan_d    = scan_q;
    tgt_d     = tgt_q;
    nxt_d     = nxt_q;
    op_d      = op_q;
    done_d    = 1'b0;
    ok_d      = ok_q;
    blk_out_d = blk_out_q;
    rew_d     = 1'b0;
    set_bad   = 1'b0;
    set_idx   = tgt_q;
    rd_idx    = tgt_q;
    case (state_q)
      ST_SCAN: begin
        state_d = ST_SCAN_WAIT;
      end
      ST_SCAN_WAIT: begin
        if (eng_done_in) begin
          set_bad = (eng_rsp_in.mark == bbm_pkg::BAD_MARK);
          set_idx = scan_q;
          scan_d  = next_blk(scan_q);
          state_d = (scan_q == AW'(BLOCKS - 1)) ? ST_IDLE : ST_SCAN;
        end
      end
      ST_IDLE: begin
        if (usr_valid_in) begin
          op_d    = usr_op_in;
          tgt_d   = usr_block_in;
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (rd_bad) begin
          if (op_q == bbm_pkg::BBM_OP_READ) begin
            done_d    = 1'b1;
            ok_d      = 1'b0;
            blk_out_d = tgt_q;
            state_d   = ST_IDLE;
          end else begin
            tgt_d = nxt_q;
            nxt_d = next_blk(nxt_q);
          end
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (eng_done_in) begin
          blk_out_d = tgt_q;
          // status bit zero set means fail
          if (op_q != bbm_pkg::BBM_OP_READ &&
              eng_rsp_in.status[bbm_pkg::STAT_FAIL_BIT]) begin
            set_bad = 1'b1;
            if (op_q == bbm_pkg::BBM_OP_PROGRAM) begin
              rew_d   = 1'b1;
              state_d = ST_ISSUE;
            end else begin
              done_d  = 1'b1;
              ok_d    = 1'b0;
              state_d = ST_IDLE;
            end
          end else begin
            rew_d   = (op_q == bbm_pkg::BBM_OP_READ) &&
                      (eng_rsp_in.ecc_fail ||
                       eng_rsp_in.ecc_errs >= EW'(ECC_BITS - 1));
            done_d  = 1'b1;
            ok_d    = !(op_q == bbm_pkg::BBM_OP_READ && eng_rsp_in.ecc_fail);
            state_d = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_SCAN;
      scan_q    <= '0;
      tgt_q     <= '0;
      nxt_q     <= '0;
      op_q      <= bbm_pkg::BBM_OP_READ;
      done_q    <= 1'b0;
      ok_q      <= 1'b0;
      blk_out_q <= '0;
      rew_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      scan_q    <= scan_d;
      tgt_q     <= tgt_d;
      nxt_q     <= nxt_d;
      op_q      <= op_d;
      done_q    <= done_d;
      ok_q      <= ok_d;
      blk_out_q <= blk_out_d;
      rew_q     <= rew_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // scan reads the marker via the read op; issue waits one cycle for lookup
  // retired targets never reach the engine
  assign eng_valid_out   = (state_q == ST_SCAN) ||
                           (state_q == ST_ISSUE && !rd_bad);
  assign eng_req_out.op  = (state_q == ST_SCAN) ? bbm_pkg::BBM_OP_READ : op_q;
  assign eng_req_out.block = (state_q == ST_SCAN) ? scan_q : tgt_q;
  assign usr_ready_out   = (state_q == ST_IDLE);
  assign usr_done_out    = done_q;
  assign usr_ok_out      = ok_q;
  assign usr_block_out   = blk_out_q;
  assign rewrite_out     = rew_q;
  assign scan_busy_out   = (state_q == ST_SCAN) || (state_q == ST_SCAN_WAIT);
  assign pad_byte_out    = bbm_pkg::PAD_BYTE;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_no_bad_erase: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    eng_valid_out && eng_req_out.op == bbm_pkg::BBM_OP_ERASE |-> !rd_bad)
    else $error("erase issued to a retired block");
  a_scan_before_use: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    scan_busy_out |-> !usr_ready_out && !usr_done_out)
    else $error("user served during scan");
  a_zero_mark_bad: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_SCAN_WAIT && eng_done_in &&
    eng_rsp_in.mark == bbm_pkg::BAD_MARK |-> set_bad && set_idx == scan_q)
    else $error("zero mark not retired");
  a_prog_fail_retry: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_WAIT && eng_done_in && op_q == bbm_pkg::BBM_OP_PROGRAM &&
    eng_rsp_in.status[bbm_pkg::STAT_FAIL_BIT]
    |=> rewrite_out && state_q == ST_ISSUE && $stable(op_q))
    else $error("program failure not retried");
  a_erase_fail_done: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_WAIT && eng_done_in && op_q == bbm_pkg::BBM_OP_ERASE &&
    eng_rsp_in.status[bbm_pkg::STAT_FAIL_BIT]
    |-> set_bad ##1 usr_done_out && !usr_ok_out)
    else $error("erase failure not retired");
  a_read_keeps_blk: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_WAIT && op_q == bbm_pkg::BBM_OP_READ |-> !set_bad)
    else $error("read error retired a block");
  a_ecc_rewrite: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_WAIT && eng_done_in && op_q == bbm_pkg::BBM_OP_READ &&
    eng_rsp_in.ecc_fail |=> rewrite_out && usr_done_out)
    else $error("uncorrectable read not flagged");
  a_redirect_bad: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_ISSUE && rd_bad && op_q != bbm_pkg::BBM_OP_READ
    |=> tgt_q == $past(nxt_q))
    else $error("retired block not redirected");
  a_status_bit: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_q == ST_WAIT && eng_done_in && op_q != bbm_pkg::BBM_OP_READ &&
    !eng_rsp_in.status[bbm_pkg::STAT_FAIL_BIT] |=> usr_done_out && usr_ok_out)
    else $error("pass status not reported");
  c_scan_end: cover property (@(posedge sys_clk_in)
    state_q == ST_SCAN_WAIT ##1 state_q == ST_IDLE);
  c_prog_fail: cover property (@(posedge sys_clk_in) rewrite_out &&
    op_q == bbm_pkg::BBM_OP_PROGRAM);
  c_erase_ok: cover property (@(posedge sys_clk_in) usr_done_out &&
    usr_ok_out && op_q == bbm_pkg::BBM_OP_ERASE);
endmodule // bbm_ctrl

//--- verification/bbm_flash_model.sv
// bbm_flash_model: behavioural flash behind its operation engine
// assumes one outstanding request at a time from the bad block manager
`timescale 1ns/100ps
module bbm_flash_model #(
  parameter logic [10:0] BAD_LIST [4] = '{11'h005, 11'h006, 11'h12c, 11'h7ff}
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 valid_in,
  input  wire bbm_pkg::bbm_req_type req_in,
  input  wire logic [10:0]          fail_blk_in,
  input  wire logic [3:0]           errs_in,
  input  wire logic                 efail_in,
  output logic                      done_out,
  output bbm_pkg::bbm_rsp_type      rsp_out,
  output logic                      misuse_out
);
  // ----
  // state
  // ----
  bbm_pkg::bbm_req_type cur;
  int                   wait_n;
  logic                 busy;
  logic                 st;

  // four bad blocks leave 2044 good, within 2008 to 2048
  function automatic logic is_bad(input logic [10:0] b);
    foreach (BAD_LIST[i]) if (BAD_LIST[i] == b) return 1'b1;
    return 1'b0;
  endfunction

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      done_out <= 1'b0;
      misuse_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      done_out <= 1'b0;
      // released bus carries noise, not the last status
      rsp_out <= bbm_pkg::bbm_rsp_type'($urandom);
      if (valid_in) begin
        cur <= req_in;
        busy <= 1'b1;
        wait_n <= $urandom_range(0, 2);
        // erasing a bad block would wipe its mark
        if (req_in.op == bbm_pkg::BBM_OP_ERASE && is_bad(req_in.block))
          misuse_out <= 1'b1;
      end else if (busy && wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else if (busy) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        // bit 0 fails program or erase; meaningless after a read
        st = (cur.op == bbm_pkg::BBM_OP_READ) ? 1'($urandom_range(0, 1))
                                              : (cur.block == fail_blk_in);
        // status byte with ready and unprotected bits high
        rsp_out.status <= {7'h70, st};
        // every page of a bad block reads back 00
        rsp_out.mark <= is_bad(cur.block) ? 8'h00 : 8'hff;
        rsp_out.ecc_errs <= errs_in;
        rsp_out.ecc_fail <= efail_in;
      end
    end
  end
endmodule // bbm_flash_model

//--- verification/bbm_ctrl_test.sv
// bbm_ctrl_test: self-checking bench for the bad block manager
// assumes the package, design and flash model are compiled before it
`timescale 1ns/100ps
module bbm_ctrl_test;
  // ----
  // signals and bench model
  // ----
  localparam logic [10:0] BAD_LIST [4] = '{11'h005, 11'h006, 11'h12c, 11'h7ff};
  logic                 sys_clk_in = 1'b0;
  logic                 rst_n_in   = 1'b0;
  logic                 usr_valid  = 1'b0;
  bbm_pkg::bbm_op_type  usr_op     = bbm_pkg::BBM_OP_READ;
  logic [10:0]          usr_blk    = '0;
  logic [10:0]          fail_blk   = 11'h7ff;
  logic [3:0]           errs       = '0;
  logic                 efail      = 1'b0;
  logic                 rdy, done, ok, rw, busy, ev, edone, misuse;
  logic                 got_ok, got_rw;
  logic [10:0]          blk_out, got_blk, b, sp0;
  logic [7:0]           pad;
  bbm_pkg::bbm_req_type ereq;
  bbm_pkg::bbm_rsp_type ersp;
  int                   fail_count = 0, total_checks = 0, eng_n = 0, n;
  int                   scan_n = 0, e;
  bit                   ret [2048];
  bit                   ef, exp_rw;

  always #50 sys_clk_in = ~sys_clk_in;

  bbm_ctrl uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .usr_valid_in(usr_valid), .usr_op_in(usr_op), .usr_block_in(usr_blk),
    .usr_ready_out(rdy), .usr_done_out(done), .usr_ok_out(ok),
    .usr_block_out(blk_out), .rewrite_out(rw), .scan_busy_out(busy),
    .pad_byte_out(pad), .eng_valid_out(ev), .eng_req_out(ereq),
    .eng_done_in(edone), .eng_rsp_in(ersp));

  bbm_flash_model #(.BAD_LIST(BAD_LIST)) flash (.clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .valid_in(ev), .req_in(ereq),
    .fail_blk_in(fail_blk), .errs_in(errs), .efail_in(efail),
    .done_out(edone), .rsp_out(ersp), .misuse_out(misuse));

  task automatic chk_bit(input string nm, input logic x, input logic g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %0b seen %0b", nm, x, g);
    end
  endtask

  task automatic chk_blk(input string nm, input logic [10:0] x,
                         input logic [10:0] g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", nm, x, g);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one user request; fault settings ride along on the same falling edge
  task automatic run_op(input bbm_pkg::bbm_op_type op, input logic [10:0] t,
                        input logic [10:0] fb = 11'h7ff,
                        input logic [3:0] er = 4'h0, input logic xf = 1'b0);
    int k;
    k = 0;
    got_rw = 1'b0;
    @(negedge sys_clk_in);
    while (rdy !== 1'b1 && k < 100) begin
      @(negedge sys_clk_in);
      k++;
    end
    usr_valid = 1'b1;
    usr_op = op;
    usr_blk = t;
    fail_blk = fb;
    errs = er;
    efail = xf;
    @(negedge sys_clk_in);
    usr_valid = 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      if (rw === 1'b1) got_rw = 1'b1;
      k++;
    end while (done !== 1'b1 && k < 300);
    got_ok = ok;
    got_blk = blk_out;
    if (k >= 300) begin
      fail_count++;
      finish_test();
    end
  endtask

  // engine requests stand one cycle; sampled mid-cycle where settled
  // the short delay lets a reset release on the same edge settle first
  always @(negedge sys_clk_in) begin
    #1;
    if (rst_n_in && ev === 1'b1) begin
      eng_n++;
      if (ereq.op == bbm_pkg::BBM_OP_ERASE)
        chk_bit("erase_target_retired", 1'b0, ret[ereq.block]);
      if (busy === 1'b1) begin
        chk_blk("scan_block", 11'(scan_n), ereq.block);
        chk_bit("scan_is_read", 1'b1, ereq.op == bbm_pkg::BBM_OP_READ);
        scan_n++;
      end
    end
  end

  initial begin
    void'($urandom(32'hcc31ee21));
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      finish_test();
    end
    chk_bit("scan_count", 1'b1, scan_n == bbm_pkg::BLOCK_COUNT);
    chk_bit("pad_ones", 1'b1, pad == 8'hff);
    foreach (BAD_LIST[i]) ret[BAD_LIST[i]] = 1'b1;
    foreach (BAD_LIST[i]) begin
      n = eng_n;
      run_op(bbm_pkg::BBM_OP_READ, BAD_LIST[i]);
      chk_bit("bad_read_ok", 1'b0, got_ok);
      chk_bit("bad_read_quiet", 1'b1, eng_n == n);
    end
    for (int i = 0; i < 2; i++) begin
      run_op(bbm_pkg::BBM_OP_ERASE, BAD_LIST[i]);
      chk_bit("erase_moved", 1'b1, got_blk != BAD_LIST[i]);
      chk_bit("spare_retired", 1'b0, ret[got_blk]);
      if (i == 1) chk_bit("spare_rotates", 1'b1, got_blk != sp0);
      sp0 = got_blk;
    end
    run_op(bbm_pkg::BBM_OP_PROGRAM, 11'd40, 11'd40);
    chk_bit("prog_fail_rewrite", 1'b1, got_rw);
    chk_bit("prog_fail_moved", 1'b1, got_blk != 11'd40);
    chk_bit("prog_redo_ok", 1'b1, got_ok);
    ret[40] = 1'b1;
    run_op(bbm_pkg::BBM_OP_READ, 11'd40);
    chk_bit("prog_fail_barred", 1'b0, got_ok);
    run_op(bbm_pkg::BBM_OP_ERASE, 11'd41, 11'd41);
    chk_bit("erase_fail_ok", 1'b0, got_ok);
    chk_blk("erase_fail_block", 11'd41, got_blk);
    ret[41] = 1'b1;
    run_op(bbm_pkg::BBM_OP_READ, 11'd41);
    chk_bit("erase_fail_barred", 1'b0, got_ok);
    run_op(bbm_pkg::BBM_OP_ERASE, 11'd41);
    chk_bit("erase_fail_moved", 1'b1, got_blk != 11'd41);
    // random reads: error counts around the near-limit threshold
    for (int i = 0; i < 40; i++) begin
      b = 11'($urandom_range(7, 2046));
      if (ret[b]) b = 11'd100;
      e = $urandom_range(0, 8);
      ef = ($urandom_range(0, 3) == 0);
      run_op(bbm_pkg::BBM_OP_READ, b, 11'h7ff, 4'(e), ef);
      exp_rw = ef || e >= bbm_pkg::ECC_MIN_BITS - 1;
      chk_bit("read_rewrite", exp_rw, got_rw);
      if (!ef) chk_bit("read_ok", 1'b1, got_ok);
      chk_blk("read_block", b, got_blk);
    end
    run_op(bbm_pkg::BBM_OP_READ, 11'd100, 11'h7ff, 4'h8, 1'b1);
    chk_bit("read_fail_flag", 1'b1, got_rw);
    run_op(bbm_pkg::BBM_OP_READ, 11'd100);
    chk_bit("read_errs_kept", 1'b1, got_ok);
    chk_blk("read_errs_block", 11'd100, got_blk);
    run_op(bbm_pkg::BBM_OP_PROGRAM, 11'd100);
    chk_bit("prog_pass_ok", 1'b1, got_ok);
    chk_blk("prog_pass_block", 11'd100, got_blk);
    run_op(bbm_pkg::BBM_OP_MARK, 11'd101);
    chk_bit("mark_op_ok", 1'b1, got_ok);
    chk_bit("bad_mark_erased", 1'b0, misuse);
    finish_test();
  end
endmodule // bbm_ctrl_test
